// [verilog/sscl_pkg.sv]
// Package for the switch short-circuit latch: constants shared by the design.
// Assumes a single 125 MHz core clock; analog comparators sit outside.
`default_nettype none
package sscl_pkg;
    // Fault count that latches the converter off
    localparam int unsigned FAULT_LIMIT = 7;
    localparam int unsigned CNT_W = 3;
    // Config word bit positions
    localparam int unsigned CFG_W = 16;
    localparam int unsigned CFG_LS_THR_BIT = 7;
    localparam int unsigned CFG_HS_EN_BIT = 8;
    // Thresholds in millivolts
    localparam logic [9:0] LS_THR_LO_MV = 10'h087;
    localparam logic [9:0] LS_THR_HI_MV = 10'h0E6;
    localparam logic [9:0] HS_THR_MV = 10'h2EE;
    localparam logic [9:0] THR_OFF_MV = 10'h000;
    // Blanking time after each switch edge
    localparam int unsigned BLANK_NS = 100;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_W = 5;
    // Gate-control state machine
    typedef enum logic [2:0] {
        SSCL_RUN = 3'b001,
        SSCL_COUNTING = 3'b010,
        SSCL_LATCHED = 3'b100
    } sscl_state_t;
endpackage : sscl_pkg
`default_nettype wire

// [verilog/sscl_top.sv]
// Short-circuit latch: blanks, counts and latches off switch faults.
// Assumes comparator outputs and PWM requests are asynchronous pins and
// that adapter reconnect drives arst_n_in low.
//
// Operation
// - Count faults; latch off at seven
// - Only adapter reconnect clears latch-off
// - Ignore comparators during blanking after edges
// - Separate low- and high-side counters
// - Low side senses switch node to ground
// - High side senses input-sense to switch node
// - Bit 7 picks 135 or 230 mV
// - Bit 8 enables high side at 750 mV
// - Non-synchronous mode keeps low gate off
// - Under-current holds low gate off, refresh excepted
`default_nettype none
module sscl_top
    import sscl_pkg::*;
#(
    parameter int unsigned LIMIT = FAULT_LIMIT
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [CFG_W-1:0] charger_config_word_in,
    input wire logic hs_pwm_req_in,
    input wire logic ls_pwm_req_in,
    input wire logic ls_cmp_in,
    input wire logic hs_cmp_in,
    input wire logic nonsync_mode_in,
    input wire logic undercurrent_guard_in,
    input wire logic bootstrap_refresh_in,
    output logic hs_gate_out,
    output logic ls_gate_out,
    output logic latched_off_out,
    output logic [9:0] ls_thr_mv_out,
    output logic [9:0] hs_thr_mv_out,
    output logic [CNT_W-1:0] ls_count_out,
    output logic [CNT_W-1:0] hs_count_out
);
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic hs_req;
    logic ls_req;
    logic ls_cmp;
    logic hs_cmp;
    logic undercur;
    logic refresh;
    logic hs_req_d;
    logic ls_req_d;
    logic [BLANK_W-1:0] hs_blank;
    logic [BLANK_W-1:0] ls_blank;
    logic ls_fault;
    logic hs_fault;
    logic [CNT_W-1:0] ls_cnt;
    logic [CNT_W-1:0] hs_cnt;
    sscl_state_t state;
    logic hs_en;

    // Two-flop synchronisers for comparator, PWM request, under-current and refresh inputs
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {bootstrap_refresh_in, undercurrent_guard_in, hs_cmp_in,
                      ls_cmp_in, ls_pwm_req_in, hs_pwm_req_in};
            sync2 <= sync1;
        end
    end
    assign hs_req = sync2[0];
    assign ls_req = sync2[1];
    assign ls_cmp = sync2[2];
    assign hs_cmp = sync2[3];
    assign undercur = sync2[4];
    assign refresh = sync2[5];
    assign hs_en = charger_config_word_in[CFG_HS_EN_BIT];

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hs_req_d <= 1'b0;
            ls_req_d <= 1'b0;
            hs_blank <= '0;
            ls_blank <= '0;
        end else begin
            hs_req_d <= hs_req;
            ls_req_d <= ls_req;
            if (hs_req != hs_req_d) begin
                hs_blank <= BLANK_W'(BLANK_CYC);
            end else if (hs_blank != '0) begin
                hs_blank <= hs_blank - 1'b1;
            end
            if (ls_req != ls_req_d) begin
                ls_blank <= BLANK_W'(BLANK_CYC);
            end else if (ls_blank != '0) begin
                ls_blank <= ls_blank - 1'b1;
            end
        end
    end

    // Low-side fault only while conducting and unblanked
    assign ls_fault = ls_cmp && ls_gate_out && (ls_blank == '0) && (ls_req == ls_req_d);
    assign hs_fault = hs_en && hs_cmp && hs_gate_out && (hs_blank == '0)
                      && (hs_req == hs_req_d);

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ls_cnt <= '0;
            hs_cnt <= '0;
        end else begin
            if (ls_fault && ls_cnt != CNT_W'(LIMIT)) begin
                ls_cnt <= ls_cnt + 1'b1;
            end
            if (hs_fault && hs_cnt != CNT_W'(LIMIT)) begin
                hs_cnt <= hs_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= SSCL_RUN;
        end else begin
            unique case (state)
                SSCL_RUN: begin
                    if (ls_cnt != '0 || hs_cnt != '0) begin
                        state <= SSCL_COUNTING;
                    end
                end
                SSCL_COUNTING: begin
                    if (ls_cnt == CNT_W'(LIMIT) || hs_cnt == CNT_W'(LIMIT)) begin
                        state <= SSCL_LATCHED;
                    end
                end
                SSCL_LATCHED: begin
                    state <= SSCL_LATCHED;
                end
                default: begin
                    state <= SSCL_LATCHED;
                end
            endcase
        end
    end

    // Gate drives and status outputs
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hs_gate_out <= 1'b0;
            ls_gate_out <= 1'b0;
            latched_off_out <= 1'b0;
        end else begin
            latched_off_out <= (state == SSCL_LATCHED);
            if (state == SSCL_LATCHED) begin
                hs_gate_out <= 1'b0;
                ls_gate_out <= 1'b0;
            end else begin
                hs_gate_out <= hs_req;
                ls_gate_out <= ls_req && !hs_req && !nonsync_mode_in
                               && (!undercur || refresh);
            end
        end
    end

    // Threshold selection and counter outputs
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ls_thr_mv_out <= LS_THR_LO_MV;
            hs_thr_mv_out <= THR_OFF_MV;
            ls_count_out <= '0;
            hs_count_out <= '0;
        end else begin
            ls_thr_mv_out <= charger_config_word_in[CFG_LS_THR_BIT] ? LS_THR_HI_MV
                                                                     : LS_THR_LO_MV;
            hs_thr_mv_out <= hs_en ? HS_THR_MV : THR_OFF_MV;
            ls_count_out <= ls_cnt;
            hs_count_out <= hs_cnt;
        end
    end

    // Checks
    property p_latch_at_limit;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (ls_cnt == CNT_W'(LIMIT) || hs_cnt == CNT_W'(LIMIT)) |-> ##[1:3] latched_off_out;
    endproperty
    a_latch_at_limit: assert property (p_latch_at_limit) else $error("no latch at limit");
    property p_latch_sticky;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        latched_off_out |=> latched_off_out;
    endproperty
    a_latch_sticky: assert property (p_latch_sticky) else $error("latch released");
    property p_blank;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (ls_blank != '0) |=> $stable(ls_cnt);
    endproperty
    a_blank: assert property (p_blank) else $error("count during blanking");
    property p_hs_off;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        !hs_en |=> $stable(hs_cnt);
    endproperty
    a_hs_off: assert property (p_hs_off) else $error("hs counted while disabled");
    property p_ls_thr;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        charger_config_word_in[CFG_LS_THR_BIT] |=> (ls_thr_mv_out == LS_THR_HI_MV);
    endproperty
    a_ls_thr: assert property (p_ls_thr) else $error("wrong ls threshold");
    property p_nonsync;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        nonsync_mode_in |=> !ls_gate_out;
    endproperty
    a_nonsync: assert property (p_nonsync) else $error("ls gate on in nonsync");
    property p_undercur;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (undercur && !refresh) |=> !ls_gate_out;
    endproperty
    a_undercur: assert property (p_undercur) else $error("ls gate on under current");
    property p_gates_off;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        latched_off_out |-> (!hs_gate_out && !ls_gate_out);
    endproperty
    a_gates_off: assert property (p_gates_off) else $error("gate on while latched");
    property p_ls_own;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        !ls_fault |=> $stable(ls_cnt);
    endproperty
    a_ls_own: assert property (p_ls_own) else $error("ls counter moved");
    property p_hs_blank;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (hs_blank != '0) |=> $stable(hs_cnt);
    endproperty
    a_hs_blank: assert property (p_hs_blank) else $error("hs count during blanking");
    // Limit reached, then shutdown two cycles later
    sequence s_at_limit;
        (ls_cnt == CNT_W'(LIMIT)) || (hs_cnt == CNT_W'(LIMIT));
    endsequence
    sequence s_shut_down;
        ##2 (latched_off_out && !hs_gate_out && !ls_gate_out);
    endsequence
    property p_latch_steps;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        s_at_limit |-> s_shut_down;
    endproperty
    a_latch_steps: assert property (p_latch_steps) else $error("no shutdown after limit");
endmodule : sscl_top
`default_nettype wire

// [test/sscl_host_model.sv]
// Host model: builds the config word from two threshold choices.
// Assumes the bench picks settings that suit the board layout.
`default_nettype none
module sscl_host_model import sscl_pkg::*; (
    input wire logic ls_high_thr_in,
    input wire logic hs_detect_en_in,
    output logic [CFG_W-1:0] charger_config_word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        charger_config_word_out = '0;
        charger_config_word_out[CFG_LS_THR_BIT] = ls_high_thr_in;
        charger_config_word_out[CFG_HS_EN_BIT] = hs_detect_en_in;
    end
endmodule : sscl_host_model
`default_nettype wire

// [test/tb.sv]
// Bench for the short-circuit latch: drives pins, judges outputs.
// Assumes the host model supplies the config word; 125 MHz clock.
`default_nettype none
module tb import sscl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, ls_sel = 0, hs_en = 0, hreq = 0, lreq = 0;
    logic lcmp = 0, hcmp = 0, nsync = 0, ucg = 0, bref = 0, hg, lg, lat;
    logic [CFG_W-1:0] cfg;
    logic [9:0] lthr, hthr;
    logic [CNT_W-1:0] lcnt, hcnt;
    int fail_count = 0, tests_run = 0, cyc = 0, k;
    sscl_host_model sscl_host_model_inst (.ls_high_thr_in(ls_sel), .hs_detect_en_in(hs_en),
        .charger_config_word_out(cfg));
    sscl_top sscl_top_inst (.core_clk_in(clk), .arst_n_in(rst_n),
        .charger_config_word_in(cfg), .hs_pwm_req_in(hreq), .ls_pwm_req_in(lreq),
        .ls_cmp_in(lcmp), .hs_cmp_in(hcmp), .nonsync_mode_in(nsync),
        .undercurrent_guard_in(ucg), .bootstrap_refresh_in(bref), .hs_gate_out(hg),
        .ls_gate_out(lg), .latched_off_out(lat), .ls_thr_mv_out(lthr),
        .hs_thr_mv_out(hthr), .ls_count_out(lcnt), .hs_count_out(hcnt));
    // Clock of 8 ns
    initial begin
        forever #4 clk = ~clk;
    end
    // Cycles then settle at the falling edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wt
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic rst;
        @(posedge clk) rst_n <= 1'b0;
        wt(6);
        @(posedge clk) rst_n <= 1'b1;
        wt(3);
    endtask : rst
    task automatic t_thr;
        chk("ls_thr", LS_THR_LO_MV, lthr);
        chk("hs_thr", THR_OFF_MV, hthr);
        chk("latched", 10'h000, {9'h000, lat});
        @(posedge clk) {ls_sel, hs_en} <= 2'b11;
        wt(3);
        chk("ls_thr", LS_THR_HI_MV, lthr);
        chk("hs_thr", HS_THR_MV, hthr);
        $display("threshold test done");
    endtask : t_thr
    task automatic t_hs;
        @(posedge clk) {hreq, hcmp} <= 2'b11;
        wt(3);
        chk("hs_gate", 10'h001, {9'h000, hg});
        for (k = 0; k < 40 && hcnt !== 3'h1; k++) wt(0);
        chk("hs_blank", 10'h001, {9'h000, k >= 10});
        wt(8);
        chk("hs_count", 10'h007, {7'h00, hcnt});
        chk("ls_count", 10'h000, {7'h00, lcnt});
        chk("latched", 10'h001, {9'h000, lat});
        @(posedge clk) {hcmp, ls_sel, lreq, hreq} <= 4'b0011;
        wt(20);
        chk("latched", 10'h001, {9'h000, lat});
        chk("gates", 10'h000, {8'h00, hg, lg});
        @(posedge clk) {lreq, hreq} <= 2'b00;
        rst();
        chk("latched", 10'h000, {9'h000, lat});
        @(posedge clk) {hs_en, hreq, hcmp} <= 3'b011;
        wt(40);
        chk("hs_count", 10'h000, {7'h00, hcnt});
        @(posedge clk) {hreq, hcmp} <= 2'b00;
        $display("high side test done");
    endtask : t_hs
    task automatic t_ls;
        @(posedge clk) lreq <= 1'b1;
        wt(4);
        chk("ls_gate", 10'h001, {9'h000, lg});
        @(posedge clk) nsync <= 1'b1;
        wt(4);
        chk("ls_gate", 10'h000, {9'h000, lg});
        @(posedge clk) {nsync, ucg} <= 2'b01;
        wt(4);
        chk("ls_gate", 10'h000, {9'h000, lg});
        @(posedge clk) bref <= 1'b1;
        wt(4);
        chk("ls_gate", 10'h001, {9'h000, lg});
        @(posedge clk) {ucg, bref, lcmp} <= 3'b001;
        for (k = 0; k < 40 && lcnt !== 3'h1; k++) wt(0);
        wt(8);
        chk("ls_count", 10'h007, {7'h00, lcnt});
        chk("hs_count", 10'h000, {7'h00, hcnt});
        chk("ls_gate", 10'h000, {9'h000, lg});
        @(posedge clk) {lcmp, lreq} <= 2'b00;
        $display("low side test done");
    endtask : t_ls
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        // Reset held for six cycles
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wt(3);
        t_thr();
        t_hs();
        t_ls();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
